//--- bench/psg_top_tb.sv
// self-checking bench for the setpoint profile generator
`timescale 1ns/100ps
module psg_top_tb
	import psg_pkg::*;
;
	localparam int unsigned TK = 40;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [ADDR_W-1:0] awaddr = '0;
	logic [ADDR_W-1:0] araddr = '0;
	logic [31:0] wdata = '0;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, prog_running;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [SP_W-1:0] setpoint_out;
	int miscompares = 0;
	int checked = 0;

	psg_top #(.TICK_CYCLES(TK)) dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(rready), .setpoint_out(setpoint_out),
		.prog_running(prog_running));

	initial begin
		forever #2 aclk = ~aclk;
	end

	task automatic final_report;
		if (miscompares == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : final_report

	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// readies sampled at the falling edge, so the rising edge decides alone
	task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic pa, pw, bv;
		pa = 1'b1;
		pw = 1'b1;
		bv = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!bv) begin
			@(negedge aclk);
			pa = pa && !s_axi_awready;
			pw = pw && !s_axi_wready;
			bv = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			awvalid <= pa;
			wvalid <= pw;
		end
		bready <= 1'b0;
	endtask : axi_wr

	task automatic axi_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic ta, rv;
		rv = 1'b0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!rv) begin
			@(negedge aclk);
			ta = arvalid && s_axi_arready;
			rv = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ta) begin
				arvalid <= 1'b0;
			end
		end
		rready <= 1'b0;
	endtask : axi_rd

	function automatic logic [31:0] mk(input logic m, input logic u,
		input logic [1:0] c, input logic [4:0] p);
		return (32'h0000_0001 << CTRL_START_BIT) | (32'(m) << CTRL_METHOD_BIT)
			| (32'(u) << CTRL_UNIT_BIT) | (32'(c) << CTRL_CODE_LSB)
			| (32'(p) << CTRL_PAT_LSB);
	endfunction : mk

	// starts a pattern and watches the setpoint until the program ends
	task automatic run_prog(input logic [31:0] ctrl, input logic [15:0] e_first,
		input logic [15:0] e_last, input int e_chg, input int lo, input int hi);
		logic [15:0] prev, first;
		logic [31:0] d;
		logic [1:0] r;
		int cyc, chg, n;
		logic seen;
		prev = setpoint_out;
		first = prev;
		cyc = 0;
		chg = 0;
		n = 0;
		seen = 1'b0;
		fork
			axi_wr(OFF_CTRL, ctrl, r);
			while (n < hi + 100 && !(seen && prog_running === 1'b0)) begin
				@(negedge aclk);
				n++;
				if (prog_running === 1'b1) begin
					seen = 1'b1;
					cyc++;
				end
				if (setpoint_out !== prev) begin
					if (chg == 0) begin
						first = setpoint_out;
					end
					chg++;
				end
				prev = setpoint_out;
			end
		join
		chk("first setpoint", first, e_first);
		chk("step count", chg, e_chg);
		chk("run length ok", cyc >= lo && cyc <= hi, 1);
		chk("final setpoint", setpoint_out, e_last);
		axi_rd(OFF_STATUS, d, r);
		chk("status done", d[1:0], 2'h2);
		axi_rd(OFF_SETPOINT, d, r);
		chk("setpoint reg", d, 32'(e_last));
	endtask : run_prog

	task automatic t_reset;
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(OFF_CTRL, d, r);
		chk("ctrl default", d, 32'h0000_0000);
		axi_rd(OFF_SSP, d, r);
		chk("ssp default", d, 32'(RST_SSP));
		axi_rd(6'h18, d, r);
		chk("unmapped rresp", r, RESP_SLVERR);
		chk("unmapped rdata", d, 32'h0000_0000);
		axi_wr(6'h18, 32'h1234_5678, r);
		chk("unmapped bresp", r, RESP_SLVERR);
	endtask : t_reset

	task automatic t_load;
		logic [1:0] r;
		axi_wr(OFF_SSP, 32'h0000_0064, r);
		axi_wr(OFF_PROG_ADDR, 32'h0000_0000, r);
		axi_wr(OFF_PROG_DATA, psg_seg_s'{1'b1, 15'h0003, 16'h00A0}, r);
		axi_wr(OFF_PROG_ADDR, 32'((NUM_PATTERNS - 1) << SEG_W), r);
		axi_wr(OFF_PROG_DATA, psg_seg_s'{1'b0, 15'h0014, 16'h0082}, r);
		axi_wr(OFF_PROG_DATA, psg_seg_s'{1'b1, 15'h0002, 16'h0082}, r);
		chk("load bresp", r, RESP_OKAY);
	endtask : t_load

	task automatic t_bad_pattern;
		logic [1:0] r;
		axi_wr(OFF_CTRL, mk(METHOD_TIME, UNIT_MMSS, START_SSP, 5'h1F), r);
		@(negedge aclk);
		chk("pattern 31 refused", prog_running, 1'b0);
	endtask : t_bad_pattern

	task automatic t_time_mmss;
		run_prog(mk(METHOD_TIME, UNIT_MMSS, START_SSP, 5'h01), 16'h0064,
			16'h00A0, 61, 2 * TK, 4 * TK);
	endtask : t_time_mmss

	task automatic t_time_hhmm;
		run_prog(mk(METHOD_TIME, UNIT_HHMM, START_SSP, 5'h01), 16'h0064,
			16'h00A0, 61, 120 * TK, 182 * TK);
	endtask : t_time_hhmm

	task automatic t_ramp;
		logic [31:0] d;
		logic [1:0] r;
		// 30 counts at 20 a minute: 90 s, then a 2 s soak
		run_prog(mk(METHOD_RAMP, UNIT_MMSS, START_SSP, 5'h1E), 16'h0064,
			16'h0082, 31, 88 * TK, 95 * TK);
		axi_rd(OFF_CTRL, d, r);
		chk("ctrl readback", d, 32'h0000_1E0C);
	endtask : t_ramp

	task automatic t_code2;
		run_prog(mk(METHOD_TIME, UNIT_MMSS, START_TIME, 5'h01), 16'h0083,
			16'h00A0, 30, 2 * TK, 4 * TK);
	endtask : t_code2

	task automatic t_code2_ramp;
		run_prog(mk(METHOD_RAMP, UNIT_MMSS, START_TIME, 5'h1E), 16'h0064,
			16'h0082, 31, 88 * TK, 95 * TK);
	endtask : t_code2_ramp

	task automatic t_code1;
		// start already on the target: segment 1 shrinks to nothing
		run_prog(mk(METHOD_RAMP, UNIT_MMSS, START_RAMP, 5'h1E), 16'h0082,
			16'h0082, 0, TK, 3 * TK + 10);
	endtask : t_code1

	// pattern kept while running, stop, then a reset in mid-run
	task automatic t_stop;
		logic [31:0] d;
		logic [1:0] r;
		axi_wr(OFF_CTRL, mk(METHOD_RAMP, UNIT_MMSS, START_SSP, 5'h1E), r);
		axi_wr(OFF_CTRL, 32'h0000_000C, r);
		axi_rd(OFF_CTRL, d, r);
		chk("pattern kept", d, 32'h0000_1E0C);
		repeat (4 * TK) @(posedge aclk);
		axi_wr(OFF_CTRL, 32'h0000_1E0E, r);
		@(negedge aclk);
		chk("stop running", prog_running, 1'b0);
		// four or five seconds at 20 a minute: one count
		chk("stop setpoint", setpoint_out, 16'h0065);
		repeat (2 * TK) @(posedge aclk);
		chk("stop holds", setpoint_out, 16'h0065);
		axi_wr(OFF_CTRL, mk(METHOD_RAMP, UNIT_MMSS, START_SSP, 5'h1E), r);
		repeat (TK) @(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		chk("reset running", prog_running, 1'b0);
		chk("reset setpoint", setpoint_out, 32'h0000_0000);
		axi_rd(OFF_CTRL, d, r);
		chk("reset ctrl", d, 32'h0000_0000);
		axi_rd(OFF_STATUS, d, r);
		chk("reset status", d, 32'h0000_0000);
	endtask : t_stop

	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_load();
		t_bad_pattern();
		t_time_mmss();
		t_time_hhmm();
		t_ramp();
		t_code2();
		t_code2_ramp();
		t_code1();
		t_stop();
		final_report();
	end

	initial begin
		#300_000;
		miscompares++;
		final_report();
	end
endmodule : psg_top_tb

//--- verilog/psg_mem.sv
// program pattern store, one write port and a registered read port
`timescale 1ns/100ps
module psg_mem
	import psg_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire psg_wr_s wr,
	input wire logic [MEM_AW-1:0] raddr,
	output psg_seg_s rdata
);
	psg_seg_s mem [MEM_DEPTH];
	psg_seg_s rdata_reg;

	always_ff @(posedge aclk) begin
		if (wr.en) begin
			mem[wr.addr] <= wr.data;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rdata_reg <= '0;
		end else begin
			rdata_reg <= mem[raddr];
		end
	end

	assign rdata = rdata_reg;
endmodule : psg_mem

//--- verilog/psg_pkg.sv
// constants, types and register map of the setpoint profile generator
package psg_pkg;
	localparam int unsigned ADDR_W = 6;
	localparam logic [ADDR_W-1:0] OFF_CTRL = 6'h00;
	localparam logic [ADDR_W-1:0] OFF_SSP = 6'h04;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 6'h08;
	localparam logic [ADDR_W-1:0] OFF_SETPOINT = 6'h0C;
	localparam logic [ADDR_W-1:0] OFF_PROG_ADDR = 6'h10;
	localparam logic [ADDR_W-1:0] OFF_PROG_DATA = 6'h14;
	localparam int unsigned CTRL_START_BIT = 0;
	localparam int unsigned CTRL_STOP_BIT = 1;
	localparam int unsigned CTRL_METHOD_BIT = 2;
	localparam int unsigned CTRL_UNIT_BIT = 3;
	localparam int unsigned CTRL_CODE_LSB = 4;
	localparam int unsigned CTRL_PAT_LSB = 8;
	localparam logic METHOD_TIME = 1'h0;
	localparam logic METHOD_RAMP = 1'h1;
	localparam logic UNIT_HHMM = 1'h0;
	localparam logic UNIT_MMSS = 1'h1;
	localparam logic [1:0] START_SSP = 2'h0;
	localparam logic [1:0] START_RAMP = 2'h1;
	localparam logic [1:0] START_TIME = 2'h2;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int unsigned NUM_PATTERNS = 30;
	localparam int unsigned PAT_W = 5;
	localparam int unsigned SEG_W = 4;
	localparam logic [SEG_W-1:0] SEG_MAX = 4'hF;
	localparam int unsigned MEM_AW = PAT_W + SEG_W;
	localparam int unsigned MEM_DEPTH = NUM_PATTERNS * (2 ** SEG_W);
	localparam int unsigned SP_W = 16;
	localparam int unsigned VAL_W = 15;
	localparam int unsigned ERR_W = 20;
	localparam int unsigned TB_W = 28;
	localparam logic [SP_W-1:0] RST_SSP = 16'h0000;
	// time base: one second of the internal clock
	localparam int unsigned TIME_BASE_NS = 1_000_000_000;
	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned TIME_BASE_CYCLES = TIME_BASE_NS / CLK_PERIOD_NS;
	localparam int unsigned SEC_PER_MIN = 60;
	// a grade is per hour or per minute: sixty time units
	localparam logic [SP_W-1:0] RAMP_DEN = 16'h003C;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_FETCH = 5'b00010,
		ST_LOAD = 5'b00100,
		ST_RUN = 5'b01000,
		ST_DONE = 5'b10000
	} psg_state_e;

	// one stored segment: end flag, time or grade, final target
	typedef struct packed {
		logic last;
		logic [VAL_W-1:0] val;
		logic [SP_W-1:0] tgt;
	} psg_seg_s;

	typedef struct packed {
		logic en;
		logic [MEM_AW-1:0] addr;
		psg_seg_s data;
	} psg_wr_s;

	typedef struct packed {
		psg_state_e st;
		logic aw_got;
		logic w_got;
		logic [ADDR_W-1:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic method;
		logic unit;
		logic [1:0] code;
		logic [PAT_W-1:0] pat;
		logic [SP_W-1:0] ssp;
		logic [MEM_AW-1:0] prog_addr;
		psg_wr_s wr;
		logic [SEG_W-1:0] seg;
		logic first;
		logic last;
		logic by_level;
		logic [SP_W-1:0] sp;
		logic [SP_W-1:0] tgt;
		logic [SP_W-1:0] num;
		logic [SP_W-1:0] den;
		logic [ERR_W-1:0] err;
		logic [VAL_W-1:0] elapsed;
		logic [VAL_W-1:0] dur;
		logic [TB_W-1:0] base_cnt;
		logic [5:0] min_cnt;
	} psg_st_s;
endpackage : psg_pkg

//--- verilog/psg_top.sv
// setpoint profile generator with AXI4-Lite register access
// Contract
// - thirty stored patterns, selected by number
// - method bit: 0 duration, 1 ramp grade
// - time unit: hh:mm default, or mm:ss
// - duration mode: reach target in exact time
// - ramp mode: grade per hour or minute
// - soak segment always takes a duration
// - code 0: start at starting target setpoint
// - code 2: current setpoint, segment time; not ramp
// - code 1: current setpoint onto ramp, shortened
//
// The implementer's own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
module psg_top
	import psg_pkg::*;
#(
	parameter int unsigned TICK_CYCLES = TIME_BASE_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [SP_W-1:0] setpoint_out,
	output logic prog_running
);
	psg_st_s s_reg;
	psg_st_s s_next;
	psg_seg_s rd;
	logic wr_fire;
	logic sec_tick;
	logic unit_tick;
	logic tick_eff;
	logic step;
	logic seg_end;
	logic up;
	logic soak;
	logic ramp_case;
	logic rate_case;
	logic ld_level;
	logic ld_jump;
	logic [1:0] code_eff;
	logic [SP_W-1:0] lo;
	logic [SP_W-1:0] hi;
	logic [SP_W-1:0] ld_start;
	logic [SP_W-1:0] ld_ref;
	logic [SP_W-1:0] ld_num;
	logic [SP_W-1:0] ld_den;
	logic [31:0] ctrl_img;
	logic [31:0] cur_word;
	logic [31:0] md;
	logic [PAT_W-1:0] md_pat;

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction : merge

	function automatic logic [31:0] map_word(input psg_st_s s,
		input logic [ADDR_W-1:0] a, input logic [31:0] ctrl);
		logic [31:0] r;
		r = '0;
		case (a)
			OFF_CTRL: r = ctrl;
			OFF_SSP: r = {16'h0000, s.ssp};
			OFF_STATUS: r = {19'h0_0000, 1'b0, s.seg, 6'h00,
				s.st == ST_DONE, s.st != ST_IDLE && s.st != ST_DONE};
			OFF_SETPOINT: r = {16'h0000, s.sp};
			OFF_PROG_ADDR: r = {23'h00_0000, s.prog_addr};
			default: r = '0;
		endcase
		return r;
	endfunction : map_word

	function automatic logic hit(input logic [ADDR_W-1:0] a);
		return a == OFF_CTRL || a == OFF_SSP || a == OFF_STATUS ||
			a == OFF_SETPOINT || a == OFF_PROG_ADDR || a == OFF_PROG_DATA;
	endfunction : hit

	// pattern number 1..30 maps to a block of sixteen segments
	psg_mem u_mem (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr(s_reg.wr),
		.raddr({s_reg.pat - 5'h1, s_reg.seg}),
		.rdata(rd)
	);

	assign s_axi_awready = ~s_reg.aw_got & ~s_reg.bvalid;
	assign s_axi_wready = ~s_reg.w_got & ~s_reg.bvalid;
	assign s_axi_bvalid = s_reg.bvalid;
	assign s_axi_bresp = s_reg.bresp;
	assign s_axi_arready = ~s_reg.rvalid;
	assign s_axi_rvalid = s_reg.rvalid;
	assign s_axi_rdata = s_reg.rdata;
	assign s_axi_rresp = s_reg.rresp;
	assign setpoint_out = s_reg.sp;
	assign prog_running = s_reg.st != ST_IDLE && s_reg.st != ST_DONE;

	assign wr_fire = s_reg.aw_got & s_reg.w_got & ~s_reg.bvalid;
	assign ctrl_img = {19'h0_0000, s_reg.pat, 2'h0, s_reg.code,
		s_reg.unit, s_reg.method, 2'h0};
	assign cur_word = map_word(s_reg, s_reg.awaddr, ctrl_img);
	assign md = merge(cur_word, s_reg.wdata, s_reg.wstrb);
	assign md_pat = md[CTRL_PAT_LSB +: PAT_W];

	assign sec_tick = s_reg.base_cnt == TB_W'(TICK_CYCLES - 1);
	assign unit_tick = sec_tick && (s_reg.unit == UNIT_MMSS ||
		s_reg.min_cnt == 6'(SEC_PER_MIN - 1));

	// current-setpoint start by time has no meaning with ramp grades
	assign code_eff = (s_reg.method == METHOD_RAMP &&
		s_reg.code == START_TIME) ? START_SSP : s_reg.code;
	assign lo = (s_reg.ssp < rd.tgt) ? s_reg.ssp : rd.tgt;
	assign hi = (s_reg.ssp < rd.tgt) ? rd.tgt : s_reg.ssp;
	always_comb begin
		ld_start = s_reg.sp;
		if (s_reg.first && code_eff == START_SSP) begin
			ld_start = s_reg.ssp;
		end else if (s_reg.first && code_eff == START_RAMP) begin
			// short of the ramp start or past the target: jump onto it
			ld_start = (s_reg.sp < lo) ? lo :
				(s_reg.sp > hi) ? hi : s_reg.sp;
		end
	end
	assign ld_ref = (s_reg.first && code_eff == START_RAMP) ?
		s_reg.ssp : ld_start;
	assign soak = rd.tgt == ld_ref;
	assign ramp_case = s_reg.method == METHOD_RAMP && !soak;
	assign rate_case = s_reg.first && code_eff == START_RAMP && !soak;
	assign ld_num = ramp_case ? {1'b0, rd.val} :
		(rd.tgt > ld_ref) ? rd.tgt - ld_ref : ld_ref - rd.tgt;
	assign ld_den = ramp_case ? RAMP_DEN : {1'b0, rd.val};
	assign ld_level = ramp_case | rate_case;
	assign ld_jump = ld_den == '0 || (ld_level && ld_num == '0);

	assign up = s_reg.tgt > s_reg.sp;
	assign step = s_reg.err >= ERR_W'(s_reg.den) && s_reg.sp != s_reg.tgt;
	assign tick_eff = unit_tick &&
		(s_reg.by_level || s_reg.elapsed != s_reg.dur);
	assign seg_end = s_reg.by_level ? s_reg.sp == s_reg.tgt :
		(s_reg.elapsed == s_reg.dur &&
		s_reg.err < ERR_W'(s_reg.den));

	always_comb begin
		s_next = s_reg;
		s_next.wr.en = 1'b0;
		s_next.base_cnt = sec_tick ? '0 : s_reg.base_cnt + 1'b1;
		if (sec_tick) begin
			s_next.min_cnt = (s_reg.min_cnt == 6'(SEC_PER_MIN - 1)) ?
				'0 : s_reg.min_cnt + 1'b1;
		end
		case (s_reg.st)
			ST_IDLE: s_next.st = ST_IDLE;
			ST_DONE: s_next.st = ST_DONE;
			ST_FETCH: s_next.st = ST_LOAD;
			ST_LOAD: begin
				s_next.sp = ld_jump ? rd.tgt : ld_start;
				s_next.tgt = rd.tgt;
				s_next.num = ld_num;
				s_next.den = ld_den;
				s_next.by_level = ld_level | ld_jump;
				s_next.dur = rd.val;
				s_next.last = rd.last;
				s_next.err = '0;
				s_next.elapsed = '0;
				s_next.st = ST_RUN;
			end
			ST_RUN: begin
				// error accumulator spreads the change evenly per tick
				s_next.err = s_reg.err +
					(tick_eff ? ERR_W'(s_reg.num) : '0) -
					(step ? ERR_W'(s_reg.den) : '0);
				if (step) begin
					s_next.sp = up ? s_reg.sp + 1'b1 : s_reg.sp - 1'b1;
				end
				if (tick_eff && !s_reg.by_level) begin
					s_next.elapsed = s_reg.elapsed + 1'b1;
				end
				if (seg_end) begin
					if (s_reg.last || s_reg.seg == SEG_MAX) begin
						s_next.st = ST_DONE;
					end else begin
						s_next.seg = s_reg.seg + 1'b1;
						s_next.first = 1'b0;
						s_next.st = ST_FETCH;
					end
				end
			end
			default: s_next.st = ST_IDLE;
		endcase

		if (s_axi_awvalid && s_axi_awready) begin
			s_next.aw_got = 1'b1;
			s_next.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			s_next.w_got = 1'b1;
			s_next.wdata = s_axi_wdata;
			s_next.wstrb = s_axi_wstrb;
		end
		if (s_reg.bvalid && s_axi_bready) begin
			s_next.bvalid = 1'b0;
		end
		if (s_reg.rvalid && s_axi_rready) begin
			s_next.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !s_reg.rvalid) begin
			s_next.rvalid = 1'b1;
			s_next.rdata = map_word(s_reg, s_axi_araddr, ctrl_img);
			s_next.rresp = hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
		end
		// commands from software override the sequencer
		if (wr_fire) begin
			s_next.aw_got = 1'b0;
			s_next.w_got = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = hit(s_reg.awaddr) ? RESP_OKAY : RESP_SLVERR;
			case (s_reg.awaddr)
				OFF_CTRL: begin
					s_next.method = md[CTRL_METHOD_BIT];
					s_next.unit = md[CTRL_UNIT_BIT];
					s_next.code = md[CTRL_CODE_LSB +: 2];
					// a running program keeps its pattern
					s_next.pat = prog_running ? s_reg.pat : md_pat;
					if (md[CTRL_STOP_BIT]) begin
						s_next.st = ST_IDLE;
					end
					if (md[CTRL_START_BIT] && md_pat != '0 &&
						md_pat <= PAT_W'(NUM_PATTERNS)) begin
						s_next.st = ST_FETCH;
						s_next.seg = '0;
						s_next.pat = md_pat;
						s_next.first = 1'b1;
					end
				end
				OFF_SSP: s_next.ssp = md[SP_W-1:0];
				OFF_PROG_ADDR: s_next.prog_addr = md[MEM_AW-1:0];
				OFF_PROG_DATA: begin
					s_next.wr.en = 1'b1;
					s_next.wr.addr = s_reg.prog_addr;
					s_next.wr.data = s_reg.wdata;
					s_next.prog_addr = s_reg.prog_addr + 1'b1;
				end
				default: s_next.bresp = RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_reg <= '0;
			s_reg.st <= ST_IDLE;
			s_reg.ssp <= RST_SSP;
			s_reg.method <= METHOD_TIME;
			s_reg.unit <= UNIT_HHMM;
		end else begin
			s_reg <= s_next;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_first_load;
		s_reg.st == ST_LOAD && s_reg.first;
	endsequence

	a_pattern_range: assert property (
		s_reg.st == ST_FETCH |-> s_reg.pat != '0 &&
		s_reg.pat <= PAT_W'(NUM_PATTERNS))
		else $error("pattern number out of range while fetching");
	a_ramp_rate: assert property (
		s_reg.st == ST_LOAD && ramp_case |=>
		s_reg.den == RAMP_DEN && s_reg.by_level)
		else $error("ramp segment not paced by grade");
	a_unit_minute: assert property (
		unit_tick && s_reg.unit == UNIT_HHMM |->
		s_reg.min_cnt == 6'(SEC_PER_MIN - 1) && sec_tick)
		else $error("minute tick out of step");
	a_time_bound: assert property (
		s_reg.st == ST_RUN && !s_reg.by_level |->
		s_reg.elapsed <= s_reg.dur)
		else $error("segment time overran");
	a_soak_time: assert property (
		s_reg.st == ST_LOAD && soak && rd.val != '0 |=>
		s_reg.den == {1'b0, $past(rd.val)} && !s_reg.by_level)
		else $error("soak segment not timed");
	a_ssp_start: assert property (
		s_first_load ##0 (code_eff == START_SSP &&
		s_reg.method == METHOD_TIME && rd.val != '0) |=>
		s_reg.sp == $past(s_reg.ssp))
		else $error("program did not start at starting setpoint");
	a_no_time_ramp: assert property (
		s_first_load ##0 (s_reg.method == METHOD_RAMP &&
		s_reg.code == START_TIME && rd.tgt != s_reg.ssp &&
		rd.val != '0) |=> s_reg.sp == $past(s_reg.ssp))
		else $error("time start used in ramp mode");
	a_onto_ramp: assert property (
		s_first_load ##0 (code_eff == START_RAMP &&
		rd.tgt >= s_reg.ssp) |=>
		s_reg.sp >= $past(s_reg.ssp) && s_reg.sp <= $past(rd.tgt))
		else $error("start not placed on the ramp");
	a_unit_step: assert property (
		s_reg.st == ST_RUN |=> s_reg.sp == $past(s_reg.sp) ||
		s_reg.sp == $past(s_reg.sp) + 16'h0001 ||
		s_reg.sp == $past(s_reg.sp) - 16'h0001)
		else $error("setpoint moved by more than one count");
	a_hold_still: assert property (
		s_reg.st != ST_RUN && s_reg.st != ST_LOAD |=> $stable(s_reg.sp))
		else $error("setpoint moved outside a segment");
endmodule : psg_top
